// file: pkg/fba_pkg.sv
// shared constants, register map and pin bundles for the alu host controller
package fba_pkg;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 10;
    localparam int SETTLE_NS = 100;
    // least time, so round up to whole cycles
    localparam int SETTLE_CYC = (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SYNC_STAGES = 2;
    // drive flop + settle + sampling chain
    localparam int WAIT_CYC = 1 + SETTLE_CYC + SYNC_STAGES;

    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_PRESET = 8'h08;
    localparam logic [31:0] CTRL_RST = 32'h0000_0000;

    // ctrl fields
    localparam int CTRL_LHS_LSB = 0;
    localparam int CTRL_RHS_LSB = 4;
    localparam int CTRL_OP_LSB = 8;
    localparam int CTRL_MODE_BIT = 12;
    localparam int CTRL_CIN_BIT = 13;
    localparam int CTRL_POL_BIT = 14;
    localparam int CTRL_WIDTH = 15;

    // status fields
    localparam int ST_RESULT_LSB = 0;
    localparam int ST_COUT_BIT = 4;
    localparam int ST_RELAY_BIT = 5;
    localparam int ST_CREATE_BIT = 6;
    localparam int ST_EQ_BIT = 7;
    localparam int ST_BUSY_BIT = 8;
    localparam int ST_MISMATCH_BIT = 9;

    // preset commands
    localparam logic [1:0] PRESET_CMP = 2'h1;
    localparam logic [1:0] PRESET_AND = 2'h2;

    // op codes, line 3 is the msb
    localparam logic [3:0] OP_SUB = 4'h6;
    localparam logic [3:0] OP_ANDCHK = 4'h4;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ------------------------------------------------------------
    // pin bundles
    // ------------------------------------------------------------
    typedef struct packed {
        logic mode;
        logic carry_in;
        logic [3:0] op_code;
        logic [3:0] rhs_word;
        logic [3:0] lhs_word;
    } fba_drive_t;

    typedef struct packed {
        logic eq_flag;
        logic create;
        logic relay;
        logic carry_out;
        logic [3:0] result_word;
    } fba_sense_t;

    typedef enum logic [1:0] {ST_IDLE, ST_SETTLE} fba_state_t;

endpackage

// file: rtl/fba_host.sv
// host controller that drives the 4-bit alu pins from axi4-lite registers
//
// The AXI4-Lite register port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ns
module fba_host
    import fba_pkg::*;
(
    // clock and reset
    input wire logic core_clk_in,
    input wire logic sys_rst_in,
    // axi4-lite write
    input wire logic [7:0] s_axi_awaddr_in,
    input wire logic s_axi_awvalid_in,
    output logic s_axi_awready_out,
    input wire logic [31:0] s_axi_wdata_in,
    input wire logic [3:0] s_axi_wstrb_in,
    input wire logic s_axi_wvalid_in,
    output logic s_axi_wready_out,
    output logic [1:0] s_axi_bresp_out,
    output logic s_axi_bvalid_out,
    input wire logic s_axi_bready_in,
    // axi4-lite read
    input wire logic [7:0] s_axi_araddr_in,
    input wire logic s_axi_arvalid_in,
    output logic s_axi_arready_out,
    output logic [31:0] s_axi_rdata_out,
    output logic [1:0] s_axi_rresp_out,
    output logic s_axi_rvalid_out,
    input wire logic s_axi_rready_in,
    // alu pins
    output fba_drive_t dev_drive_out,
    input wire fba_sense_t dev_sense_in
);

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic is_reg(input logic [7:0] a, input logic [7:0] r);
        is_reg = (a[7:2] == r[7:2]);
    endfunction

    logic aw_held_r, w_held_r, awready_r, wready_r, bvalid_r;
    logic [1:0] bresp_r;
    logic [7:0] awaddr_r;
    logic [31:0] wdata_r;
    logic [3:0] wstrb_r;
    logic arready_r, rvalid_r;
    logic [1:0] rresp_r;
    logic [31:0] rdata_r;
    logic [CTRL_WIDTH-1:0] ctrl_r, ctrl_nxt;
    fba_drive_t drv_r;
    fba_sense_t sync1_r, sync2_r;
    logic [3:0] res_r;
    logic cout_r, relay_r, create_r, eq_r, mismatch_r, busy_r;
    fba_state_t state_r;
    logic [7:0] cnt_r;
    logic start_r;
    logic aw_take, w_take, wr_fire, ar_take, hit_ctrl, hit_preset;

    assign aw_take = s_axi_awvalid_in & awready_r;
    assign w_take = s_axi_wvalid_in & wready_r;
    assign wr_fire = aw_held_r & w_held_r & ~bvalid_r;
    assign ar_take = s_axi_arvalid_in & arready_r;
    assign hit_ctrl = is_reg(awaddr_r, REG_CTRL);
    assign hit_preset = is_reg(awaddr_r, REG_PRESET);

    // ------------------------------------------------------------
    // axi write channel
    // ------------------------------------------------------------
    // one write in flight; ready returns only after the response is taken
    always_ff @(posedge core_clk_in) begin
        if (sys_rst_in) begin
            aw_held_r <= 1'b0;
            w_held_r <= 1'b0;
            awready_r <= 1'b1;
            wready_r <= 1'b1;
            bvalid_r <= 1'b0;
            bresp_r <= RESP_OKAY;
            awaddr_r <= 8'h00;
            wdata_r <= 32'h0000_0000;
            wstrb_r <= 4'h0;
        end else begin
            if (aw_take) begin
                aw_held_r <= 1'b1;
                awaddr_r <= s_axi_awaddr_in;
                awready_r <= 1'b0;
            end
            if (w_take) begin
                w_held_r <= 1'b1;
                wdata_r <= s_axi_wdata_in;
                wstrb_r <= s_axi_wstrb_in;
                wready_r <= 1'b0;
            end
            if (wr_fire) begin
                aw_held_r <= 1'b0;
                w_held_r <= 1'b0;
                bvalid_r <= 1'b1;
                bresp_r <= (hit_ctrl | hit_preset) ? RESP_OKAY : RESP_SLVERR;
            end
            if (bvalid_r && s_axi_bready_in) begin
                bvalid_r <= 1'b0;
                awready_r <= 1'b1;
                wready_r <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // control register and presets
    // ------------------------------------------------------------
    always_comb begin
        ctrl_nxt = ctrl_r;
        if (hit_ctrl) begin
            if (wstrb_r[0])
                ctrl_nxt[7:0] = wdata_r[7:0];
            if (wstrb_r[1])
                ctrl_nxt[CTRL_WIDTH-1:8] = wdata_r[CTRL_WIDTH-1:8];
        end else if (hit_preset && wstrb_r[0]) begin
            if (wdata_r[1:0] == PRESET_CMP) begin
                ctrl_nxt[CTRL_OP_LSB +: 4] = OP_SUB;
                ctrl_nxt[CTRL_MODE_BIT] = 1'b0;
                ctrl_nxt[CTRL_CIN_BIT] = 1'b1;
            end else if (wdata_r[1:0] == PRESET_AND) begin
                ctrl_nxt[CTRL_OP_LSB +: 4] = OP_ANDCHK;
                ctrl_nxt[CTRL_MODE_BIT] = 1'b1;
            end
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (sys_rst_in) begin
            ctrl_r <= CTRL_RST[CTRL_WIDTH-1:0];
            start_r <= 1'b0;
        end else begin
            start_r <= wr_fire & (hit_ctrl | hit_preset);
            if (wr_fire)
                ctrl_r <= ctrl_nxt;
        end
    end

    // ------------------------------------------------------------
    // pin drive
    // ------------------------------------------------------------
    always_ff @(posedge core_clk_in) begin
        if (sys_rst_in) begin
            drv_r <= '0;
        end else begin
            drv_r.lhs_word <= ctrl_r[CTRL_LHS_LSB +: 4];
            drv_r.rhs_word <= ctrl_r[CTRL_RHS_LSB +: 4];
            drv_r.op_code <= ctrl_r[CTRL_OP_LSB +: 4];
            drv_r.mode <= ctrl_r[CTRL_MODE_BIT];
            // active-high view: carry pin is active low
            drv_r.carry_in <= ctrl_r[CTRL_CIN_BIT] ^ ctrl_r[CTRL_POL_BIT];
        end
    end

    // ------------------------------------------------------------
    // sampling and capture
    // ------------------------------------------------------------
    // device is combinational, so only a settle wait separates drive and read
    always_ff @(posedge core_clk_in) begin
        if (sys_rst_in) begin
            sync1_r <= '0;
            sync2_r <= '0;
        end else begin
            sync1_r <= dev_sense_in;
            sync2_r <= sync1_r;
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (sys_rst_in) begin
            state_r <= ST_IDLE;
            cnt_r <= 8'h00;
            busy_r <= 1'b0;
        end else if (start_r) begin
            // a new ctrl or preset write restarts the wait
            state_r <= ST_SETTLE;
            cnt_r <= 8'h00;
            busy_r <= 1'b1;
        end else begin
            unique case (state_r)
                ST_IDLE: begin
                    busy_r <= 1'b0;
                end
                ST_SETTLE: begin
                    if (cnt_r == 8'(WAIT_CYC - 1)) begin
                        state_r <= ST_IDLE;
                        busy_r <= 1'b0;
                    end else begin
                        cnt_r <= cnt_r + 8'h01;
                    end
                end
                default: begin
                    state_r <= ST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (sys_rst_in) begin
            res_r <= 4'h0;
            cout_r <= 1'b0;
            relay_r <= 1'b0;
            create_r <= 1'b0;
            eq_r <= 1'b0;
            mismatch_r <= 1'b0;
        end else if (state_r == ST_SETTLE && cnt_r == 8'(WAIT_CYC - 1)) begin
            res_r <= sync2_r.result_word;
            cout_r <= sync2_r.carry_out ^ ctrl_r[CTRL_POL_BIT];
            relay_r <= sync2_r.relay;
            create_r <= sync2_r.create;
            eq_r <= sync2_r.eq_flag;
            // equal words: flag released high while relay is low
            mismatch_r <= sync2_r.eq_flag == sync2_r.relay;
        end
    end

    // ------------------------------------------------------------
    // axi read channel
    // ------------------------------------------------------------
    always_ff @(posedge core_clk_in) begin
        if (sys_rst_in) begin
            arready_r <= 1'b1;
            rvalid_r <= 1'b0;
            rresp_r <= RESP_OKAY;
            rdata_r <= 32'h0000_0000;
        end else if (ar_take) begin
            arready_r <= 1'b0;
            rvalid_r <= 1'b1;
            rresp_r <= RESP_OKAY;
            rdata_r <= 32'h0000_0000;
            if (is_reg(s_axi_araddr_in, REG_CTRL)) begin
                rdata_r[CTRL_WIDTH-1:0] <= ctrl_r;
            end else if (is_reg(s_axi_araddr_in, REG_STATUS)) begin
                rdata_r[ST_RESULT_LSB +: 4] <= res_r;
                rdata_r[ST_COUT_BIT] <= cout_r;
                rdata_r[ST_RELAY_BIT] <= relay_r;
                rdata_r[ST_CREATE_BIT] <= create_r;
                rdata_r[ST_EQ_BIT] <= eq_r;
                rdata_r[ST_BUSY_BIT] <= busy_r;
                rdata_r[ST_MISMATCH_BIT] <= mismatch_r;
            end else if (!is_reg(s_axi_araddr_in, REG_PRESET)) begin
                rresp_r <= RESP_SLVERR;
            end
        end else if (rvalid_r && s_axi_rready_in) begin
            rvalid_r <= 1'b0;
            arready_r <= 1'b1;
        end
    end

    assign s_axi_awready_out = awready_r;
    assign s_axi_wready_out = wready_r;
    assign s_axi_bvalid_out = bvalid_r;
    assign s_axi_bresp_out = bresp_r;
    assign s_axi_arready_out = arready_r;
    assign s_axi_rvalid_out = rvalid_r;
    assign s_axi_rresp_out = rresp_r;
    assign s_axi_rdata_out = rdata_r;
    assign dev_drive_out = drv_r;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (sys_rst_in);

    sequence preset_write(logic [1:0] cmd);
        wr_fire && hit_preset && wstrb_r[0] && wdata_r[1:0] == cmd;
    endsequence

    chk_cmp_preset_pins: assert property (
        preset_write(PRESET_CMP) |-> ##2
            (drv_r.op_code == OP_SUB && !drv_r.mode))
        else $error("compare preset did not drive subtract code");

    chk_arith_mode_low: assert property (
        preset_write(PRESET_CMP) |-> ##2 !drv_r.mode [*1] ##1 1'b1)
        else $error("arithmetic preset left mode high");

    chk_and_preset_pins: assert property (
        preset_write(PRESET_AND) |-> ##2
            (drv_r.op_code == OP_ANDCHK && drv_r.mode))
        else $error("both-high preset did not drive its code");

    chk_carry_polarity: assert property (
        $stable(ctrl_r) [*2] |->
            drv_r.carry_in == (ctrl_r[CTRL_CIN_BIT] ^ ctrl_r[CTRL_POL_BIT]))
        else $error("carry pin polarity wrong");

    chk_parity_capture: assert property (
        (state_r == ST_SETTLE && cnt_r == 8'(WAIT_CYC - 1)) |=>
            mismatch_r == (eq_r == relay_r))
        else $error("parity mismatch bit not consistent");

    chk_settle_wait: assert property (
        start_r |=> busy_r [*8] ##0 (state_r == ST_SETTLE))
        else $error("capture happened before settle time");

endmodule

// file: tb/fba_alu_model.sv
// behavioural model of the 4-bit alu, status variant, open-drain eq flag
`timescale 1ns/1ns
module fba_alu_model
    import fba_pkg::*;
#(
    parameter int DLY_NS = 40
) (
    // pins from host
    input wire fba_drive_t drive_in,
    // pins to host
    output logic [3:0] result_out,
    output logic carry_out_out,
    output logic relay_out,
    output logic create_out,
    output logic eq_pull_out
);
    logic [3:0] a, b, s, t, u, f, g, p;
    logic [4:0] sum;
    logic rl, cr, co;
    // ------------------------------------------------------------
    // function generator, active-high data view
    // ------------------------------------------------------------
    always_comb begin
        a = drive_in.lhs_word;
        b = drive_in.rhs_word;
        s = drive_in.op_code;
        t = a | (b & {4{s[0]}}) | (~b & {4{s[1]}});
        u = (a & b & {4{s[3]}}) | (a & ~b & {4{s[2]}});
        sum = {1'b0, t} + {1'b0, u} + {4'h0, ~drive_in.carry_in};
        g = t & u;
        p = t | u;
        f = drive_in.mode ? ~(t ^ u) : sum[3:0];
        if (drive_in.mode) begin
            rl = |(~f);
            cr = 1'b1;
            co = ~rl & drive_in.carry_in;
        end else begin
            rl = ~&p;
            cr = ~(g[3] | p[3] & g[2] | &p[3:2] & g[1] | &p[3:1] & g[0]);
            co = ~sum[4];
        end
    end
    // pins lag the inputs, well inside the host's settle wait
    assign #DLY_NS result_out = f;
    assign #DLY_NS carry_out_out = co;
    assign #DLY_NS relay_out = rl;
    assign #DLY_NS create_out = cr;
    // only ever pulls low, the bench supplies the pull-up
    assign #DLY_NS eq_pull_out = ~&f;
endmodule

// file: tb/tb_fba_host.sv
// self-checking bench for the alu host controller
`timescale 1ns/1ns
module tb_fba_host;
    import fba_pkg::*;
    logic clk, rst, awvalid, wvalid, bready, arvalid, rready;
    logic awready, wready, bvalid, arready, rvalid, eq_pull;
    logic m_cout, m_relay, m_create;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata, st, d;
    logic [3:0] wstrb, m_res, a, b, f;
    logic [1:0] bresp, rresp, r;
    logic [4:0] e5;
    logic [3:0] ops [5] = '{4'h9, 4'h6, 4'hC, 4'hF, 4'h0};
    logic [3:0] lops [6] = '{4'h6, 4'h4, 4'hB, 4'h1, 4'hE, 4'h9};
    fba_drive_t drv;
    fba_sense_t sns;
    int n_mismatch, check_count, cyc;
    // pull-up resolves the open-drain flag
    assign sns = {~eq_pull, m_create, m_relay, m_cout, m_res};
    fba_host fba_host_inst (.core_clk_in(clk), .sys_rst_in(rst),
        .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid),
        .s_axi_awready_out(awready), .s_axi_wdata_in(wdata),
        .s_axi_wstrb_in(wstrb), .s_axi_wvalid_in(wvalid),
        .s_axi_wready_out(wready), .s_axi_bresp_out(bresp),
        .s_axi_bvalid_out(bvalid), .s_axi_bready_in(bready),
        .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid),
        .s_axi_arready_out(arready), .s_axi_rdata_out(rdata),
        .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rvalid),
        .s_axi_rready_in(rready), .dev_drive_out(drv),
        .dev_sense_in(sns));
    fba_alu_model fba_alu_model_inst (.drive_in(drv), .result_out(m_res),
        .carry_out_out(m_cout), .relay_out(m_relay),
        .create_out(m_create), .eq_pull_out(eq_pull));
    // ------------------------------------------------------------
    // clock, timeout, report
    // ------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task automatic end_sim();
        $display("mismatches %0d checks %0d", n_mismatch, check_count);
        if (n_mismatch == 0 && check_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            n_mismatch++;
            end_sim();
        end
    end
    task automatic chk_val(string nm, logic [31:0] e, g, m);
        check_count++;
        if ((g & m) !== (e & m)) begin
            n_mismatch++;
            $display("mismatch %s exp %h got %h", nm, e & m, g & m);
        end
    endtask
    task automatic chk_resp(string nm, logic [1:0] e, g);
        check_count++;
        if (g !== e) begin
            n_mismatch++;
            $display("mismatch %s exp %h got %h", nm, e, g);
        end
    endtask
    // ------------------------------------------------------------
    // axi4-lite master
    // ------------------------------------------------------------
    task automatic wr(logic [7:0] ad, logic [31:0] dt, logic [3:0] sb,
                      output logic [1:0] rs);
        logic aw, w;
        @(posedge clk);
        awaddr <= ad;
        wdata <= dt;
        wstrb <= sb;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        aw = 1'b0;
        w = 1'b0;
        while (!(aw && w)) begin
            @(posedge clk);
            if (!aw && awready === 1'b1) begin
                aw = 1'b1;
                awvalid <= 1'b0;
            end
            if (!w && wready === 1'b1) begin
                w = 1'b1;
                wvalid <= 1'b0;
            end
        end
        while (bvalid !== 1'b1) @(posedge clk);
        rs = bresp;
        bready <= 1'b0;
    endtask
    task automatic rd(logic [7:0] ad, output logic [31:0] dt,
                      output logic [1:0] rs);
        @(posedge clk);
        araddr <= ad;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge clk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        while (rvalid !== 1'b1) @(posedge clk);
        dt = rdata;
        rs = rresp;
        rready <= 1'b0;
    endtask
    // write, then poll status until the settle wait ends
    task automatic run(logic [7:0] ad, logic [31:0] dt);
        int k;
        wr(ad, dt, 4'hF, r);
        k = 0;
        do begin
            rd(REG_STATUS, st, r);
            k++;
        end while (st[ST_BUSY_BIT] !== 1'b0 && k < 30);
        // a poll that runs out leaves busy set and counts as a mismatch
        chk_val("busy clear", 32'h0, st, 32'h100);
    endtask
    // status bits 9:0 for logic mode, status variant
    task automatic chk_logic(string nm, logic [3:0] ef, logic c, m);
        logic rl;
        rl = |(~ef);
        chk_val(nm, {24'h0, &ef, 1'b1, rl, ~rl & c, ef}, st, m);
    endtask
    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        {rst, awvalid, wvalid, bready, arvalid, rready} = 6'h20;
        {awaddr, araddr, wdata, wstrb} = '0;
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        rd(REG_CTRL, d, r);
        chk_val("ctrl reset", CTRL_RST, d, '1);
        rd(8'h0C, d, r);
        chk_resp("unmapped read", RESP_SLVERR, r);
        wr(REG_STATUS, 32'hFF, 4'hF, r);
        chk_resp("status write", RESP_SLVERR, r);
        rd(REG_PRESET, d, r);
        chk_val("preset read", 32'h0, d, '1);
        chk_resp("preset read resp", RESP_OKAY, r);
        wr(REG_CTRL, 32'h0, 4'hF, r);
        chk_resp("ctrl write resp", RESP_OKAY, r);
        rd(REG_STATUS, st, r);
        chk_val("busy", 32'h100, st, 32'h100);
        wr(REG_CTRL, 32'h7FFF, 4'h1, r);
        rd(REG_CTRL, d, r);
        chk_val("ctrl strobe", 32'hFF, d, '1);
        // arithmetic, active-high view: mode low enables carries
        for (int i = 0; i < 10; i++) begin
            a = i[0] ? 4'hF : 4'h9;
            b = i[0] ? 4'hF : 4'h3;
            for (int c = 0; c < 2; c++) begin
                run(REG_CTRL, {18'h1, c[0], 1'b0, ops[i / 2], b, a});
                f = i < 2 ? b : i < 4 ? ~b : i < 6 ? a : i < 8 ? 4'hF : 4'h0;
                e5 = {1'b0, a} + {1'b0, f} + {4'h0, c[0]};
                chk_val("arith", {27'h0, e5}, st, 32'h1F);
            end
        end
        // magnitude compare, active-low view
        for (int i = 0; i < 3; i++) begin
            a = i == 2 ? 4'h4 : 4'h3;
            b = i == 1 ? 4'h4 : 4'h3;
            run(REG_CTRL, {24'h0, b, a});
            run(REG_PRESET, {30'h0, PRESET_CMP});
            chk_val("cmp cin1", {24'h0, a == b, 2'h0, a <= b, 4'h0}, st, 32'h90);
            // preset must have loaded op, mode and carry in before the rewrite
            rd(REG_CTRL, d, r);
            chk_val("preset cmp", 32'h2600, d, 32'h3F00);
            run(REG_CTRL, {20'h0, OP_SUB, b, a});
            chk_val("cmp cin0", {27'h0, a < b, 4'h0}, st, 32'h10);
        end
        // logic mode functions and status terms
        for (int i = 0; i < 18; i++) begin
            a = i % 3 == 2 ? 4'hC : 4'h5;
            b = i % 3 == 0 ? 4'h5 : i % 3 == 1 ? 4'h7 : 4'hA;
            run(REG_CTRL, {18'h0, i[0], 1'b1, lops[i / 3], b, a});
            case (lops[i / 3])
                4'h6: f = a ^ b;
                4'h4: f = ~(a & b);
                4'hB: f = a & b;
                4'h1: f = ~(a | b);
                4'hE: f = a | b;
                default: f = ~(a ^ b);
            endcase
            chk_logic("logic", f, i[0], 32'h3FF);
        end
        // both-high check through preset
        run(REG_CTRL, 32'h36);
        run(REG_PRESET, {30'h0, PRESET_AND});
        chk_logic("both high", 4'hD, 1'b0, 32'h3FF);
        rd(REG_CTRL, d, r);
        chk_val("preset and", 32'h1400, d, 32'h1F00);
        end_sim();
    end
endmodule
